// ===== core/mcuit_defines.svh
// Constants for the instruction timing core: field positions, timing counts, reset values.
// Assumes inclusion by bare name from the core and ALU sources.
`ifndef MCUIT_DEFINES_SVH
`define MCUIT_DEFINES_SVH

// =====================================================================
// Instruction word fields
`define MCUIT_OP_MSB 17
`define MCUIT_OP_LSB 12
`define MCUIT_BIT_MSB 10
`define MCUIT_BIT_LSB 8
`define MCUIT_ARG_MSB 7
`define MCUIT_ARG_LSB 0

// =====================================================================
// Timing: system clocks per instruction cycle and the phase that commits
`define MCUIT_CLKS_PER_CYCLE 4
`define MCUIT_PHASE_FETCH 2'h0
`define MCUIT_PHASE_EXEC 2'h2
`define MCUIT_PHASE_LAST 2'h3

// =====================================================================
// Addresses and reset values
`define MCUIT_PCL_ADDR 8'h06
`define MCUIT_PC_RST 12'h000
`define MCUIT_BYTE_RST 8'h00
`define MCUIT_BYTE_MAX 9'h0FF

`endif

// ===== core/mcuit_pkg.sv
// Types shared by the instruction timing core and its ALU.
// Assumes nothing beyond a SystemVerilog compiler.
package mcuit_pkg;

    // =====================================================================
    // Operation codes
    typedef enum logic [5:0] {
        nop_op                = 6'b000000,
        move_mem_to_acc_op    = 6'b000001,
        move_acc_to_mem_op    = 6'b000010,
        move_imm_to_acc_op    = 6'b000011,
        add_mem_op            = 6'b000100,
        add_to_mem_op         = 6'b000101,
        add_imm_op            = 6'b000110,
        sub_mem_op            = 6'b000111,
        sub_to_mem_op         = 6'b001000,
        sub_imm_op            = 6'b001001,
        and_mem_op            = 6'b001010,
        or_mem_op             = 6'b001011,
        xor_mem_op            = 6'b001100,
        and_to_mem_op         = 6'b001101,
        or_to_mem_op          = 6'b001110,
        xor_to_mem_op         = 6'b001111,
        complement_op         = 6'b010000,
        complement_to_acc_op  = 6'b010001,
        increment_op          = 6'b010010,
        increment_to_acc_op   = 6'b010011,
        decrement_op          = 6'b010100,
        decrement_to_acc_op   = 6'b010101,
        rotate_right_op       = 6'b010110,
        rotate_left_op        = 6'b010111,
        rotate_right_carry_op = 6'b011000,
        rotate_left_carry_op  = 6'b011001,
        single_bit_set_op     = 6'b011010,
        single_bit_clear_op   = 6'b011011,
        skip_zero_op          = 6'b011100,
        skip_nonzero_op       = 6'b011101,
        skip_bit_zero_op      = 6'b011110,
        skip_bit_nonzero_op   = 6'b011111,
        skip_zero_to_acc_op   = 6'b100000,
        unconditional_jump_op = 6'b100001,
        subroutine_call_op    = 6'b100010,
        subroutine_return_op  = 6'b100011,
        interrupt_return_op   = 6'b100100,
        table_read_op         = 6'b100101
    } mcuit_op_type;

endpackage : mcuit_pkg

// ===== core/mcuit_alu_if.sv
// Operand and result bundle between the sequencer and the ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/1ps
interface mcuit_alu_if;
    import mcuit_pkg::*;
    mcuit_op_type op;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [2:0] bit_idx;
    logic c_in;
    logic [7:0] res;
    logic c_out;
    logic z_out;
    logic wr_acc;
    logic wr_mem;
    logic upd_c;
    logic upd_z;
    logic skip;
    modport core (output op, acc, mem, imm, bit_idx, c_in,
                  input res, c_out, z_out, wr_acc, wr_mem, upd_c, upd_z, skip);
    modport alu (input op, acc, mem, imm, bit_idx, c_in,
                 output res, c_out, z_out, wr_acc, wr_mem, upd_c, upd_z, skip);
endinterface : mcuit_alu_if

// ===== core/mcuit_alu.sv
// Combinational ALU: result, flags, write targets and skip decision per operation.
// Assumes operands are stable for the whole execute phase.
`timescale 1ns/1ps
`include "mcuit_defines.svh"
module mcuit_alu (
    mcuit_alu_if.alu bus // Operands in, results out
);
    import mcuit_pkg::*;

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == `MCUIT_BYTE_RST);
    endfunction : is_zero

    logic [8:0] sum;
    logic [8:0] diff;
    logic [7:0] rhs;
    logic [7:0] bit_mask;

    always_comb begin
        rhs = (bus.op == add_imm_op || bus.op == sub_imm_op) ? bus.imm : bus.mem;
        sum = {1'b0, bus.acc} + {1'b0, rhs};
        diff = {1'b0, bus.acc} - {1'b0, rhs};
        bit_mask = 8'h01 << bus.bit_idx;
    end

    // =====================================================================
    // Operation decode
    always_comb begin
        bus.res = bus.acc;
        bus.c_out = bus.c_in;
        bus.wr_acc = 1'b0;
        bus.wr_mem = 1'b0;
        bus.upd_c = 1'b0;
        bus.upd_z = 1'b0;
        bus.skip = 1'b0;
        unique case (bus.op)
            move_mem_to_acc_op: begin
                bus.res = bus.mem;
                bus.wr_acc = 1'b1;
            end
            move_acc_to_mem_op: bus.wr_mem = 1'b1;
            move_imm_to_acc_op: begin
                bus.res = bus.imm;
                bus.wr_acc = 1'b1;
            end
            add_mem_op, add_to_mem_op, add_imm_op: begin
                bus.res = sum[7:0];
                bus.c_out = sum[8];
                bus.upd_c = 1'b1;
                bus.upd_z = 1'b1;
                bus.wr_mem = (bus.op == add_to_mem_op);
                bus.wr_acc = !bus.wr_mem;
            end
            sub_mem_op, sub_to_mem_op, sub_imm_op: begin
                bus.res = diff[7:0];
                bus.c_out = diff[8];
                bus.upd_c = 1'b1;
                bus.upd_z = 1'b1;
                bus.wr_mem = (bus.op == sub_to_mem_op);
                bus.wr_acc = !bus.wr_mem;
            end
            and_mem_op, and_to_mem_op, or_mem_op, or_to_mem_op, xor_mem_op, xor_to_mem_op: begin
                if (bus.op == and_mem_op || bus.op == and_to_mem_op) begin
                    bus.res = bus.acc & bus.mem;
                end else if (bus.op == or_mem_op || bus.op == or_to_mem_op) begin
                    bus.res = bus.acc | bus.mem;
                end else begin
                    bus.res = bus.acc ^ bus.mem;
                end
                bus.upd_z = 1'b1;
                bus.wr_mem = (bus.op == and_to_mem_op || bus.op == or_to_mem_op || bus.op == xor_to_mem_op);
                bus.wr_acc = !bus.wr_mem;
            end
            complement_op, complement_to_acc_op: begin
                bus.res = ~bus.mem;
                bus.upd_z = 1'b1;
                bus.wr_mem = (bus.op == complement_op);
                bus.wr_acc = !bus.wr_mem;
            end
            increment_op, increment_to_acc_op, decrement_op, decrement_to_acc_op: begin
                if (bus.op == increment_op || bus.op == increment_to_acc_op) begin
                    bus.res = bus.mem + 8'h01;
                end else begin
                    bus.res = bus.mem - 8'h01;
                end
                bus.upd_z = 1'b1;
                bus.wr_mem = (bus.op == increment_op || bus.op == decrement_op);
                bus.wr_acc = !bus.wr_mem;
            end
            rotate_right_op: begin
                bus.res = {bus.mem[0], bus.mem[7:1]};
                bus.wr_mem = 1'b1;
            end
            rotate_left_op: begin
                bus.res = {bus.mem[6:0], bus.mem[7]};
                bus.wr_mem = 1'b1;
            end
            rotate_right_carry_op: begin
                bus.res = {bus.c_in, bus.mem[7:1]};
                bus.c_out = bus.mem[0];
                bus.upd_c = 1'b1;
                bus.wr_mem = 1'b1;
            end
            rotate_left_carry_op: begin
                bus.res = {bus.mem[6:0], bus.c_in};
                bus.c_out = bus.mem[7];
                bus.upd_c = 1'b1;
                bus.wr_mem = 1'b1;
            end
            single_bit_set_op: begin
                bus.res = bus.mem | bit_mask;
                bus.wr_mem = 1'b1;
            end
            single_bit_clear_op: begin
                bus.res = bus.mem & ~bit_mask;
                bus.wr_mem = 1'b1;
            end
            skip_zero_op: bus.skip = is_zero(bus.mem);
            skip_nonzero_op: bus.skip = !is_zero(bus.mem);
            skip_bit_zero_op: bus.skip = !bus.mem[bus.bit_idx];
            skip_bit_nonzero_op: bus.skip = bus.mem[bus.bit_idx];
            skip_zero_to_acc_op: begin
                bus.res = bus.mem;
                bus.wr_acc = 1'b1;
                bus.skip = is_zero(bus.mem);
            end
            default: bus.res = bus.acc;
        endcase
        bus.z_out = is_zero(bus.res);
    end

endmodule : mcuit_alu

// ===== core/mcuit_core.sv
// Instruction sequencer of an 8-bit core: four-clock instruction cycles, branch and skip timing, stack.
// Assumes program and data memories answer combinationally within the same clock.
`timescale 1ns/1ps
`include "mcuit_defines.svh"

module mcuit_core #(
    parameter int PC_W = 12,
    parameter int INSTR_W = 18,
    parameter int STACK_DEPTH = 8
) (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic ce, // Clock enable; low freezes all state except the reset synchronizer
    output logic [PC_W-1:0] prog_addr, // Program memory address
    input wire logic [INSTR_W-1:0] prog_data, // Program memory word
    output logic [7:0] dm_addr, // Data memory address
    input wire logic [7:0] dm_rdata, // Data memory read data
    output logic [7:0] dm_wdata, // Data memory write data
    output logic dm_we, // Data memory write strobe
    output logic [7:0] acc, // Accumulator
    output logic zero_flag, // Zero flag
    output logic carry_flag, // Carry or borrow flag
    output logic int_enable // Set by interrupt return
);
    import mcuit_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // =====================================================================
    // Reset release
    logic rst_meta_r;
    logic rst_n_sync_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_sync_r <= rst_meta_r;
        end
    end

    // =====================================================================
    // State
    logic [1:0] phase_r;
    logic wait_r;
    logic tbl_r;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic wait_nxt;
    logic [PC_W-1:0] prog_addr_r;
    logic [INSTR_W-1:0] instr_r;
    logic [7:0] acc_r;
    logic [7:0] dm_wdata_r;
    logic dm_we_r;
    logic zero_r;
    logic carry_r;
    logic int_en_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [SP_W-1:0] sp_r;
    logic exec;
    logic pcl_wr;
    mcuit_op_type op;
    logic [7:0] arg;
    logic [7:0] mem_val;

    mcuit_alu_if alu_if ();
    mcuit_alu u_alu (
        .bus(alu_if.alu)
    );

    assign op = mcuit_op_type'(instr_r[`MCUIT_OP_MSB:`MCUIT_OP_LSB]);
    assign arg = instr_r[`MCUIT_ARG_MSB:`MCUIT_ARG_LSB];
    // The low program counter byte reads back as the live counter, not memory
    assign mem_val = (arg == `MCUIT_PCL_ADDR) ? pc_r[7:0] : dm_rdata;
    assign exec = ce && phase_r == `MCUIT_PHASE_EXEC && !wait_r && !tbl_r;
    assign pcl_wr = alu_if.wr_mem && arg == `MCUIT_PCL_ADDR;

    assign alu_if.op = op;
    assign alu_if.acc = acc_r;
    assign alu_if.mem = mem_val;
    assign alu_if.imm = arg;
    assign alu_if.bit_idx = instr_r[`MCUIT_BIT_MSB:`MCUIT_BIT_LSB];
    assign alu_if.c_in = carry_r;

    // =====================================================================
    // Next program counter
    always_comb begin
        pc_nxt = pc_r + PC_W'(1);
        wait_nxt = 1'b0;
        if (op == unconditional_jump_op || op == subroutine_call_op) begin
            pc_nxt = instr_r[PC_W-1:0];
            wait_nxt = 1'b1;
        end else if (op == subroutine_return_op || op == interrupt_return_op) begin
            pc_nxt = stack_r[sp_r - SP_W'(1)];
            wait_nxt = 1'b1;
        end else if (pcl_wr) begin
            pc_nxt = {pc_r[PC_W-1:8], alu_if.res};
            wait_nxt = 1'b1;
        end else if (alu_if.skip) begin
            // Skipped word is bypassed by the dead cycle rather than executed
            pc_nxt = pc_r + PC_W'(2);
            wait_nxt = 1'b1;
        end
    end

    // =====================================================================
    // Sequencer: four phases per instruction cycle
    always_ff @(posedge mclk or negedge rst_n_sync_r) begin
        if (!rst_n_sync_r) begin
            phase_r <= `MCUIT_PHASE_FETCH;
            wait_r <= 1'b0;
            tbl_r <= 1'b0;
            pc_r <= `MCUIT_PC_RST;
            prog_addr_r <= `MCUIT_PC_RST;
            instr_r <= '0;
        end else if (ce) begin
            phase_r <= phase_r + 2'h1;
            if (phase_r == `MCUIT_PHASE_FETCH && !wait_r && !tbl_r) begin
                instr_r <= prog_data;
            end
            if (phase_r == `MCUIT_PHASE_EXEC) begin
                if (wait_r) begin
                    wait_r <= 1'b0;
                end else if (tbl_r) begin
                    tbl_r <= 1'b0;
                    prog_addr_r <= pc_r;
                end else begin
                    pc_r <= pc_nxt;
                    wait_r <= wait_nxt;
                    tbl_r <= (op == table_read_op);
                    prog_addr_r <= (op == table_read_op) ? PC_W'(mem_val) : pc_nxt;
                end
            end
        end
    end

    // =====================================================================
    // Accumulator, flags and data memory write
    always_ff @(posedge mclk or negedge rst_n_sync_r) begin
        if (!rst_n_sync_r) begin
            acc_r <= `MCUIT_BYTE_RST;
            zero_r <= 1'b0;
            carry_r <= 1'b0;
            dm_we_r <= 1'b0;
            dm_wdata_r <= `MCUIT_BYTE_RST;
        end else if (ce) begin
            // Write lands during the last phase while the address is still held
            dm_we_r <= exec && alu_if.wr_mem && !pcl_wr;
            if (exec) begin
                dm_wdata_r <= alu_if.res;
                if (alu_if.wr_acc) begin
                    acc_r <= alu_if.res;
                end
                if (alu_if.upd_z) begin
                    zero_r <= alu_if.z_out;
                end
                if (alu_if.upd_c) begin
                    carry_r <= alu_if.c_out;
                end
            end else if (tbl_r && phase_r == `MCUIT_PHASE_EXEC) begin
                acc_r <= prog_data[7:0];
            end
        end
    end

    // =====================================================================
    // Return stack; overflow wraps and silently overwrites the oldest entry
    always_ff @(posedge mclk or negedge rst_n_sync_r) begin
        if (!rst_n_sync_r) begin
            sp_r <= '0;
            int_en_r <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_r[i] <= `MCUIT_PC_RST;
            end
        end else if (exec) begin
            if (op == subroutine_call_op) begin
                stack_r[sp_r] <= pc_r + PC_W'(1);
                sp_r <= sp_r + SP_W'(1);
            end else if (op == subroutine_return_op || op == interrupt_return_op) begin
                sp_r <= sp_r - SP_W'(1);
                if (op == interrupt_return_op) begin
                    int_en_r <= 1'b1;
                end
            end
        end
    end

    assign prog_addr = prog_addr_r;
    assign dm_addr = arg;
    assign dm_wdata = dm_wdata_r;
    assign dm_we = dm_we_r;
    assign acc = acc_r;
    assign zero_flag = zero_r;
    assign carry_flag = carry_r;
    assign int_enable = int_en_r;

    // =====================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_sync_r);

    a_phase_wrap: assert property (ce && phase_r == `MCUIT_PHASE_LAST |=> phase_r == `MCUIT_PHASE_FETCH)
        else $error("phase did not wrap after four clocks");
    a_phase_freeze: assert property (!ce |=> $stable(phase_r) && $stable(pc_r))
        else $error("state moved with clock enable low");
    a_plain_single: assert property (exec && !wait_nxt && op != table_read_op |=> !wait_r
        && !tbl_r && pc_r == $past(pc_r) + PC_W'(1))
        else $error("ordinary instruction took extra cycle");
    a_jump_dead: assert property (exec && op == unconditional_jump_op |=> wait_r
        && pc_r == $past(instr_r[PC_W-1:0]))
        else $error("jump did not start a dead cycle");
    // Stalls stretch the dead cycle, so its end is tied to the enabled execute phase, not a clock count
    a_dead_once: assert property (ce && wait_r && phase_r == `MCUIT_PHASE_EXEC |=> !wait_r)
        else $error("dead cycle lasted more than one instruction cycle");
    a_dead_hold: assert property (wait_r && !(ce && phase_r == `MCUIT_PHASE_EXEC) |=> wait_r)
        else $error("dead cycle ended early");
    a_pcl_jump: assert property (exec && pcl_wr |=> wait_r && !dm_we_r && pc_r[7:0] == $past(alu_if.res))
        else $error("low counter write did not jump");
    a_skip_extra: assert property (exec && alu_if.skip |=> wait_r && pc_r == $past(pc_r) + PC_W'(2))
        else $error("taken skip timing wrong");
    a_skip_bit: assert property (exec && op == skip_bit_zero_op |-> alu_if.skip == !mem_val[alu_if.bit_idx])
        else $error("bit skip decision wrong");
    a_logic_zero: assert property (exec && op == xor_mem_op |=> zero_r == (acc_r == `MCUIT_BYTE_RST))
        else $error("zero flag not set from logic result");
    a_rotate_carry: assert property (exec && op == rotate_left_carry_op |=>
        carry_r == $past(mem_val[7]) && dm_wdata_r == {$past(mem_val[6:0]), $past(carry_r)})
        else $error("rotate through carry wrong");
    a_inc_one: assert property (exec && op == increment_to_acc_op |=> acc_r == $past(mem_val) + 8'h01)
        else $error("increment not by one");
    a_add_carry: assert property (exec && op == add_mem_op |=> carry_r
        == (({1'b0, $past(acc_r)} + {1'b0, $past(mem_val)}) > `MCUIT_BYTE_MAX))
        else $error("add carry wrong");
    a_call_return: assert property (exec && op == subroutine_call_op |=> stack_r[sp_r - SP_W'(1)]
        == $past(pc_r) + PC_W'(1))
        else $error("call saved wrong return address");
    a_bit_clear: assert property (exec && op == single_bit_clear_op |=> dm_we_r
        && dm_wdata_r == ($past(mem_val) & ~(8'h01 << $past(alu_if.bit_idx))))
        else $error("bit clear touched other bits");

    c_call: cover property (exec && op == subroutine_call_op);
    c_return: cover property (exec && op == subroutine_return_op);
    c_skip_taken: cover property (exec && alu_if.skip);
    c_pcl_write: cover property (exec && pcl_wr);
    c_table_read: cover property (exec && op == table_read_op);

endmodule : mcuit_core

// ===== test/tb.sv
// Self-checking bench for mcuit_core: random programs run against an instruction-level model.
// Assumes combinational program and data memories, modelled here as arrays.
`timescale 1ns/1ps
module tb;
    import mcuit_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b0;
    logic [11:0] prog_addr;
    logic [17:0] prog_data;
    logic [7:0] dm_addr, dm_rdata, dm_wdata, acc;
    logic dm_we, zero_flag, carry_flag, int_enable;
    logic [17:0] pm [0:255];
    logic [7:0] dm [0:255];
    int seed = 7474;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int ecount = 0;
    int e0 = -1;
    int q_a[$], q_d[$], q_t[$];
    int m_acc, m_z, m_c, m_ie, m_cyc;

    mcuit_core dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
        .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we), .acc(acc),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .int_enable(int_enable));
    assign prog_data = pm[prog_addr[7:0]];
    assign dm_rdata = dm[dm_addr];

    initial begin
        forever #50 mclk = ~mclk;
    end
    // Random stalls stretch every count, so timing is measured in enabled edges only
    always @(negedge mclk) ce <= ($random(seed) & 3) != 0;

    // =====================================================================
    // Compare and close
    task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte
    task automatic chk_int(string n, int e, int g);
        total_checks++;
        if (g != e) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_int
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    function automatic logic [17:0] word(mcuit_op_type o, int arg);
        return {o, 12'(arg)};
    endfunction : word

    // =====================================================================
    // Write monitor: every store is matched against the model's queue
    task automatic check_write();
        if (q_a.size() == 0) begin
            chk_int("unexpected write", 0, 1);
            return;
        end
        if (e0 < 0) e0 = ecount - 4 * q_t[0];
        chk_byte("write addr", 8'(q_a[0]), dm_addr);
        chk_byte("write data", 8'(q_d[0]), dm_wdata);
        chk_int("write time", 4 * q_t[0], ecount - e0);
        void'(q_a.pop_front());
        void'(q_d.pop_front());
        void'(q_t.pop_front());
    endtask : check_write
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            close_out();
        end
        if (reset_n && ce) begin
            if (dm_we === 1'b1) begin
                dm[dm_addr] <= dm_wdata;
                check_write();
            end
            ecount++;
        end
    end

    // =====================================================================
    // Instruction-level model
    task automatic model(int halt);
        int pc, npc, op, a, b, m, r, s, cost, dst, sp, n;
        int md [0:255];
        int stk [0:7];
        logic [17:0] w;
        for (int i = 0; i < 256; i++) md[i] = dm[i];
        pc = 0;
        sp = 0;
        m_acc = 0;
        m_z = 0;
        m_c = 0;
        m_ie = 0;
        m_cyc = 0;
        for (n = 0; n < 400 && pc != halt; n++) begin
            w = pm[pc];
            op = w[17:12];
            b = w[10:8];
            a = w[7:0];
            m = (a == 6) ? (pc & 255) : md[a];
            npc = pc + 1;
            cost = 1;
            dst = 0;
            r = 0;
            case (op)
                1: m_acc = m;
                2: begin r = m_acc; dst = 2; end
                3: m_acc = a;
                4, 5, 6, 7, 8, 9: begin
                    s = (op < 7) ? m_acc + ((op == 6) ? a : m) : m_acc - ((op == 9) ? a : m);
                    m_c = (s > 255 || s < 0);
                    r = s & 255;
                    dst = (op == 5 || op == 8) ? 2 : 1;
                end
                10, 11, 12, 13, 14, 15: begin
                    r = (op % 3 == 1) ? (m_acc & m) : (op % 3 == 2) ? (m_acc | m) : (m_acc ^ m);
                    dst = (op > 12) ? 2 : 1;
                end
                16, 17, 18, 19, 20, 21: begin
                    r = ((op < 18) ? ~m : (op < 20) ? m + 1 : m - 1) & 255;
                    dst = (op % 2 == 0) ? 2 : 1;
                end
                22: r = (m >> 1) | ((m & 1) << 7);
                23: r = ((m << 1) & 255) | (m >> 7);
                24: r = (m >> 1) | (m_c << 7);
                25: r = ((m << 1) & 255) | m_c;
                26: r = m | (1 << b);
                27: r = m & ~(1 << b) & 255;
                28, 29, 30, 31, 32: begin
                    s = (op == 30 || op == 31) ? ((m >> b) & 1) : (m != 0);
                    if (op == 32) m_acc = m;
                    if ((op % 2 == 0) ? (s == 0) : (s != 0)) cost = 2;
                    npc = pc + cost;
                end
                33: npc = w[11:0];
                34: begin stk[sp] = pc + 1; sp = (sp + 1) % 8; npc = w[11:0]; end
                35, 36: begin sp = (sp + 7) % 8; npc = stk[sp]; if (op == 36) m_ie = 1; end
                37: m_acc = pm[m][7:0];
                default: ;
            endcase
            if (op >= 33 && op <= 37) cost = 2;
            if (op == 24 || op == 25) m_c = (op == 24) ? (m & 1) : (m >> 7);
            if (op >= 22 && op <= 27) dst = 2;
            if (op >= 4 && op <= 21) m_z = (r == 0);
            if (dst == 1) m_acc = r;
            if (dst == 2 && a == 6) begin npc = (pc & 12'hF00) | r; cost = 2; end
            else if (dst == 2) begin md[a] = r; q_a.push_back(a); q_d.push_back(r); q_t.push_back(m_cyc); end
            m_cyc += cost;
            pc = npc & 12'hFFF;
        end
    endtask : model

    // =====================================================================
    // Program build: random body, then call, table read, return, jump, low-byte jump, interrupt return, store
    task automatic run_prog(int k);
        @(negedge mclk);
        reset_n = 1'b0;
        q_a.delete();
        q_d.delete();
        q_t.delete();
        for (int i = 0; i < 256; i++) begin pm[i] = 18'h0; dm[i] = 8'($random(seed)); end
        pm[0] = word(move_acc_to_mem_op, 8'h30);
        // Last body word stays a nop, so a taken skip can never bypass the call
        for (int i = 1; i < k - 1; i++) pm[i] = {6'($unsigned($random(seed)) % 33), 1'b0, 3'($random(seed)), 5'h04, 3'($random(seed))};
        pm[k] = word(subroutine_call_op, 8'h40);
        pm[8'h40] = word(table_read_op, 8'h28);
        pm[8'h41] = word(move_acc_to_mem_op, 8'h31);
        pm[8'h42] = word(subroutine_return_op, 8'h00);
        pm[k + 1] = word(unconditional_jump_op, k + 3);
        pm[k + 2] = word(move_acc_to_mem_op, 8'h32);
        pm[k + 3] = word(move_acc_to_mem_op, 8'h06);
        pm[k + 4] = word(move_acc_to_mem_op, 8'h33);
        pm[k + 5] = word(subroutine_call_op, 8'h50);
        pm[8'h50] = word(interrupt_return_op, 8'h00);
        // Final store times the return, jump, low-byte jump, call and interrupt return before it
        pm[k + 6] = word(move_acc_to_mem_op, 8'h34);
        pm[k + 7] = word(unconditional_jump_op, k + 7);
        dm[8'h28] = 8'h90;
        pm[8'h90] = word(nop_op, k + 5);
        model(k + 7);
        repeat (8) @(negedge mclk);
        ecount = 0;
        e0 = -1;
        reset_n = 1'b1;
        while (ecount < 4 * m_cyc + 48) @(negedge mclk);
        chk_int("pending writes", 0, q_a.size());
        chk_byte("acc", 8'(m_acc), acc);
        chk_byte("zero flag", 8'(m_z), {7'h00, zero_flag});
        chk_byte("carry flag", 8'(m_c), {7'h00, carry_flag});
        chk_byte("int enable", 8'(m_ie), {7'h00, int_enable});
    endtask : run_prog

    initial begin
        for (int p = 0; p < 8; p++) run_prog(6 + 4 * p);
        close_out();
    end
endmodule : tb
